// *** core/emp_port_cfg.sv ***
// Function
// - Duplex bit: one full, zero half
// - Transmit flow control enable, resets off
// - Receive flow control enable, resets off
// - Ten/hundred speed bit when not gigabit
// - Gigabit bit selects 1000 Mb/s
// - Receive clock delay enable, resets off
// - Transmit clock delay enable, resets on
// - MII mode bit: MAC or PHY clocks
// - RMII mode bit: reference clock direction
// - RGMII mode bit enables in-band status
// - Interface type: MII, RMII, RGMII
// - Gigabit, mode, type reset from straps
// - Status shows in-band duplex, read-only
// - Status shows in-band clock speed code
// - Status shows in-band link, read-only
//
// Design decision made here: register access over AHB-Lite.
`include "emp_defs.svh"
`default_nettype none
module emp_port_cfg (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic gigabit_speed_strap,
   input wire logic port_role_strap,
   input wire logic [1:0] iface_type_strap,
   input wire logic link_clk,
   input wire logic link_rx_ctl,
   input wire logic [3:0] link_rxd,
   output emp_pkg::emp_cfg_t cfg
);

   emp_pkg::emp_sys_t s;
   emp_pkg::emp_sys_t next_s;
   emp_pkg::emp_link_t l;
   emp_pkg::emp_link_t next_l;

   // ***********************************
   // Address decode
   // ***********************************
   function automatic emp_pkg::emp_sel_t emp_dec(input logic [31:0] a);
      emp_pkg::emp_sel_t r;
      r = emp_pkg::EMP_SEL_NONE;
      if (a == `EMP_ADDR(`EMP_IDX_CTRL0)) begin
         r = emp_pkg::EMP_SEL_C0;
      end else if (a == `EMP_ADDR(`EMP_IDX_CTRL1)) begin
         r = emp_pkg::EMP_SEL_C1;
      end else if (a == `EMP_ADDR(`EMP_IDX_STAT)) begin
         r = emp_pkg::EMP_SEL_ST;
      end
      return r;
   endfunction

   // ***********************************
   // Interface type check
   // ***********************************
   function automatic logic emp_type_ok(
      input logic [1:0] t
   );
      logic ok;
      ok = 1'b1;
      if (t == `EMP_TYPE_RESV) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   // ***********************************
   // Address phase taken
   // ***********************************
   function automatic logic emp_take(
      input logic sel,
      input logic [1:0] trans,
      input logic rdy,
      input emp_pkg::emp_boot_t b
   );
      logic run;
      run = b == emp_pkg::EMP_BOOT_RUN;
      return sel && trans[1] && rdy && run;
   endfunction

   // ***********************************
   // Control one from straps
   // ***********************************
   function automatic logic [7:0] emp_strap_ctrl1(
      input logic [7:0] c1,
      input emp_pkg::emp_strap_t stp
   );
      logic [7:0] r;
      r = c1;
      r[`EMP_C1_GIG] = stp.gig;
      r[`EMP_C1_MODE] = stp.role;
      if (emp_type_ok(stp.iface)) begin
         r[`EMP_C1_TYPE_HI:`EMP_C1_TYPE_LO] = stp.iface;
      end
      return r;
   endfunction

   // ***********************************
   // Control zero write
   // ***********************************
   function automatic logic [7:0] emp_wr_ctrl0(
      input logic [31:0] wd
   );
      logic [7:0] r;
      r = 8'h00;
      r[`EMP_C0_DUPLEX] = wd[`EMP_C0_DUPLEX];
      r[`EMP_C0_TXFC] = wd[`EMP_C0_TXFC];
      r[`EMP_C0_SPD100] = wd[`EMP_C0_SPD100];
      r[`EMP_C0_RXFC] = wd[`EMP_C0_RXFC];
      r[2:0] = wd[2:0];
      return r;
   endfunction

   // ***********************************
   // Control one write
   // ***********************************
   function automatic logic [7:0] emp_wr_ctrl1(
      input logic [7:0] c1,
      input logic [31:0] wd
   );
      logic [7:0] r;
      r = c1;
      r[7] = wd[7];
      r[`EMP_C1_GIG] = wd[`EMP_C1_GIG];
      r[5] = wd[5];
      r[`EMP_C1_RXDLY] = wd[`EMP_C1_RXDLY];
      r[`EMP_C1_TXDLY] = wd[`EMP_C1_TXDLY];
      r[`EMP_C1_MODE] = wd[`EMP_C1_MODE];
      if (emp_type_ok(wd[1:0])) begin
         r[`EMP_C1_TYPE_HI:`EMP_C1_TYPE_LO] = wd[1:0];
      end
      return r;
   endfunction

   // ***********************************
   // Status write
   // ***********************************
   function automatic logic [7:0] emp_stat_wr(
      input logic [7:0] st,
      input logic [31:0] wd
   );
      logic [7:0] r;
      r = st;
      // Upper nibble is plain storage
      r[7:4] = wd[7:4];
      return r;
   endfunction

   // ***********************************
   // In-band status merge
   // ***********************************
   function automatic logic [7:0] emp_stat_merge(
      input logic [7:0] st,
      input logic [3:0] rep
   );
      logic [7:0] r;
      r = st;
      r[`EMP_ST_DUP] = rep[3];
      r[`EMP_ST_SPD_HI:`EMP_ST_SPD_LO] = rep[2:1];
      r[`EMP_ST_LINK] = rep[0];
      return r;
   endfunction

   // ***********************************
   // Handshake pending
   // ***********************************
   function automatic logic emp_ack_due(
      input logic req,
      input logic ack
   );
      // Toggle from the link side not yet answered
      return req != ack;
   endfunction

   // ***********************************
   // Read data
   // ***********************************
   function automatic logic [31:0] emp_rd_word(
      input emp_pkg::emp_sel_t sel,
      input logic [7:0] c0,
      input logic [7:0] c1,
      input logic [7:0] st
   );
      logic [31:0] r;
      r = 32'h00000000;
      case (sel)
         emp_pkg::EMP_SEL_C0: begin
            r = {24'h000000, c0};
         end
         emp_pkg::EMP_SEL_C1: begin
            r = {24'h000000, c1};
         end
         emp_pkg::EMP_SEL_ST: begin
            r = {24'h000000, st};
         end
         default: begin
            r = 32'h00000000;
         end
      endcase
      return r;
   endfunction

   // ***********************************
   // Configuration outputs
   // ***********************************
   function automatic emp_pkg::emp_cfg_t emp_cfg_of(
      input logic [7:0] c0,
      input logic [7:0] c1
   );
      emp_pkg::emp_cfg_t r;
      logic mii;
      logic rmii;
      logic rgmii;
      logic mode;
      r = '0;
      mode = c1[`EMP_C1_MODE];
      mii = c1[1:0] == `EMP_TYPE_MII;
      rmii = c1[1:0] == `EMP_TYPE_RMII;
      rgmii = c1[1:0] == `EMP_TYPE_RGMII;
      r.iface = c1[1:0];
      r.full_duplex = c0[`EMP_C0_DUPLEX];
      r.tx_flow_en = c0[`EMP_C0_TXFC];
      r.rx_flow_en = c0[`EMP_C0_RXFC];
      r.speed_1000 = c1[`EMP_C1_GIG];
      // Ten/hundred bit ignored at gigabit
      r.speed_100 = c0[`EMP_C0_SPD100] & !c1[`EMP_C1_GIG];
      r.rx_clock_delay_enable = c1[`EMP_C1_RXDLY];
      r.tx_clock_delay_enable = c1[`EMP_C1_TXDLY];
      r.inband_enable = mode && rgmii;
      // PHY role: device drives both MII clocks
      r.txc_oe_n = !(!mode && mii);
      // Reference clock made here in RMII PHY role
      r.ref_clock_out_en = !mode && rmii;
      r.rxc_oe_n = !(!r.txc_oe_n || r.ref_clock_out_en);
      return r;
   endfunction

   // ***********************************
   // In-band capture condition
   // ***********************************
   function automatic logic emp_link_take(
      input emp_pkg::emp_link_t ls,
      input logic rx_ctl,
      input logic [3:0] rxd
   );
      logic idle;
      logic free;
      logic fresh;
      idle = !rx_ctl;
      free = ls.req == ls.ack_s2;
      fresh = rxd != ls.hold;
      return idle && free && fresh && ls.en_s2;
   endfunction

   // ***********************************
   // System clock domain
   // ***********************************
   always_comb begin
      next_s = s;
      next_s.stp_s1 = {gigabit_speed_strap, port_role_strap,
         iface_type_strap};
      next_s.stp_s2 = s.stp_s1;
      next_s.req_s1 = l.req;
      next_s.req_s2 = s.req_s1;
      next_s.hresp = 1'b0;

      // Strap load once synchronisers have settled
      case (s.boot)
         emp_pkg::EMP_BOOT_W0: begin
            next_s.boot = emp_pkg::EMP_BOOT_W1;
         end
         emp_pkg::EMP_BOOT_W1: begin
            next_s.boot = emp_pkg::EMP_BOOT_W2;
         end
         emp_pkg::EMP_BOOT_W2: begin
            next_s.ctrl1 = emp_strap_ctrl1(s.ctrl1, s.stp_s2);
            next_s.boot = emp_pkg::EMP_BOOT_RUN;
            next_s.hreadyout = 1'b1;
         end
         default: begin
            next_s.boot = emp_pkg::EMP_BOOT_RUN;
         end
      endcase

      // Data phase write
      if (s.dph_wr) begin
         case (s.dph_sel)
            emp_pkg::EMP_SEL_C0: begin
               next_s.ctrl0 = emp_wr_ctrl0(hwdata);
            end
            emp_pkg::EMP_SEL_C1: begin
               next_s.ctrl1 = emp_wr_ctrl1(s.ctrl1, hwdata);
            end
            emp_pkg::EMP_SEL_ST: begin
               next_s.stat = emp_stat_wr(s.stat, hwdata);
            end
            default: begin
               next_s.stat = s.stat;
            end
         endcase
      end

      // In-band status handshake from the link side
      if (emp_ack_due(s.req_s2, s.ack)) begin
         next_s.ack = s.req_s2;
         if (s.cfg.inband_enable) begin
            next_s.stat = emp_stat_merge(next_s.stat, l.hold);
         end
      end

      // Address phase; read data built from post-write values
      next_s.dph_wr = 1'b0;
      next_s.dph_sel = emp_pkg::EMP_SEL_NONE;
      if (emp_take(hsel, htrans, hready, s.boot)) begin
         next_s.dph_sel = emp_dec(haddr);
         next_s.dph_wr = hwrite;
         if (!hwrite) begin
            next_s.hrdata = emp_rd_word(emp_dec(haddr), next_s.ctrl0,
               next_s.ctrl1, next_s.stat);
         end
      end

      // Configuration outputs
      next_s.cfg = emp_cfg_of(next_s.ctrl0, next_s.ctrl1);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.ctrl0 <= `EMP_CTRL0_RST;
         s.ctrl1 <= `EMP_CTRL1_RST;
         s.stat <= `EMP_STAT_RST;
         s.cfg.rxc_oe_n <= 1'b1;
         s.cfg.txc_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ***********************************
   // Link clock domain
   // ***********************************
   always_comb begin
      next_l = l;
      next_l.en_s1 = s.cfg.inband_enable;
      next_l.en_s2 = l.en_s1;
      next_l.ack_s1 = s.ack;
      next_l.ack_s2 = l.ack_s1;
      // Idle between frames carries link, speed, duplex
      if (emp_link_take(l, link_rx_ctl, link_rxd)) begin
         next_l.hold = link_rxd;
         next_l.req = !l.req;
      end
   end

   always_ff @(posedge link_clk or negedge hresetn) begin
      if (!hresetn) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // ***********************************
   // Outputs
   // ***********************************
   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign cfg = s.cfg;

endmodule
`default_nettype wire

// *** core/emp_defs.svh ***
`ifndef EMP_DEFS_SVH
`define EMP_DEFS_SVH

// ***********************************
// Register indices and byte addresses
// ***********************************
`define EMP_IDX_CTRL0 16'h3300
`define EMP_IDX_CTRL1 16'h3301
`define EMP_IDX_STAT 16'h3303
`define EMP_ADDR(i) {14'h0000, (i), 2'h0}

// ***********************************
// Field positions
// ***********************************
`define EMP_C0_DUPLEX 6
`define EMP_C0_TXFC 5
`define EMP_C0_SPD100 4
`define EMP_C0_RXFC 3
`define EMP_C1_GIG 6
`define EMP_C1_RXDLY 4
`define EMP_C1_TXDLY 3
`define EMP_C1_MODE 2
`define EMP_C1_TYPE_HI 1
`define EMP_C1_TYPE_LO 0
`define EMP_ST_DUP 3
`define EMP_ST_SPD_HI 2
`define EMP_ST_SPD_LO 1
`define EMP_ST_LINK 0

// ***********************************
// Reset values and encodings
// ***********************************
`define EMP_CTRL0_RST 8'h50
`define EMP_CTRL1_RST 8'h08
`define EMP_STAT_RST 8'h00
`define EMP_TYPE_MII 2'h0
`define EMP_TYPE_RMII 2'h1
`define EMP_TYPE_RESV 2'h2
`define EMP_TYPE_RGMII 2'h3
`define EMP_SPD_125 2'h2
`define EMP_SPD_25 2'h1
`define EMP_SPD_2P5 2'h0

`endif

// *** core/emp_pkg.sv ***
`default_nettype none
package emp_pkg;

   typedef enum logic [1:0] {
      EMP_BOOT_W0,
      EMP_BOOT_W1,
      EMP_BOOT_W2,
      EMP_BOOT_RUN
   } emp_boot_t;

   typedef enum logic [1:0] {
      EMP_SEL_NONE,
      EMP_SEL_C0,
      EMP_SEL_C1,
      EMP_SEL_ST
   } emp_sel_t;

   // Port configuration driven to the MAC and pads
   typedef struct packed {
      logic [1:0] iface;
      logic full_duplex;
      logic tx_flow_en;
      logic rx_flow_en;
      logic speed_1000;
      logic speed_100;
      logic rx_clock_delay_enable;
      logic tx_clock_delay_enable;
      logic inband_enable;
      logic rxc_oe_n;
      logic txc_oe_n;
      logic ref_clock_out_en;
   } emp_cfg_t;

   // Straps: gigabit, role, interface type
   typedef struct packed {
      logic gig;
      logic role;
      logic [1:0] iface;
   } emp_strap_t;

   typedef struct packed {
      emp_boot_t boot;
      emp_strap_t stp_s1;
      emp_strap_t stp_s2;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] stat;
      logic dph_wr;
      emp_sel_t dph_sel;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic req_s1;
      logic req_s2;
      logic ack;
      emp_cfg_t cfg;
   } emp_sys_t;

   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic ack_s1;
      logic ack_s2;
      logic req;
      logic [3:0] hold;
   } emp_link_t;

endpackage
`default_nettype wire

// *** sim/emp_port_cfg_checker.sv ***
`default_nettype none
module emp_port_cfg_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire emp_pkg::emp_cfg_t cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic tk;
   assign tk = hsel & htrans[1] & hready;
   chk_ctrl0_write: assert property (
      tk && hwrite && haddr == 32'h0000cc00 ##1 1 |=>
      {cfg.full_duplex, cfg.tx_flow_en, cfg.rx_flow_en} ==
      {$past(hwdata[6]), $past(hwdata[5]), $past(hwdata[3])})
      else $error("control zero write not applied");
   chk_ctrl1_write: assert property (
      tk && hwrite && haddr == 32'h0000cc04 ##1 1 |=>
      {cfg.speed_1000, cfg.rx_clock_delay_enable,
      cfg.tx_clock_delay_enable} ==
      {$past(hwdata[6]), $past(hwdata[4]), $past(hwdata[3])})
      else $error("control one write not applied");
   chk_ctrl0_upper: assert property (
      tk && !hwrite && haddr == 32'h0000cc00 |=> hrdata[31:7] == 25'h0)
      else $error("control zero reserved bits not zero");
   chk_gig_wins: assert property (
      cfg.speed_1000 |-> !cfg.speed_100)
      else $error("ten/hundred speed active at gigabit");
   chk_inband_rgmii: assert property (
      cfg.inband_enable |-> cfg.iface == 2'h3)
      else $error("in-band enabled outside reduced gigabit");
   chk_type_legal: assert property (
      cfg.iface != 2'h2)
      else $error("reserved interface type applied");
   chk_mii_clocks: assert property (
      !cfg.txc_oe_n |-> cfg.iface == 2'h0 && !cfg.rxc_oe_n)
      else $error("clock drive outside MII PHY role");
   chk_ref_out: assert property (
      cfg.ref_clock_out_en |-> cfg.iface == 2'h1 && !cfg.rxc_oe_n)
      else $error("reference clock out outside RMII");
endmodule
bind emp_port_cfg emp_port_cfg_checker chk_i (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .cfg(cfg));
`default_nettype wire

// *** sim/emp_phy_model.sv ***
`default_nettype none
module emp_phy_model (
   input wire logic link_clk,
   input wire logic [3:0] status,
   input wire logic frame,
   output logic link_rx_ctl,
   output logic [3:0] link_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   initial cnt = 4'h0;
   // Idle carries status, frames carry changing data
   always @(posedge link_clk) begin
      cnt <= cnt + 4'h1;
      link_rx_ctl <= frame;
      link_rxd <= frame ? cnt : status;
   end
endmodule
`default_nettype wire

// *** sim/ext_mac_port_interface_config_test.sv ***
`default_nettype none
module ext_mac_port_interface_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hready, link_clk, frame;
   logic hreadyout, link_rx_ctl;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [3:0] link_rxd, st;
   logic [3:0] sv [4] = '{4'hd, 4'h3, 4'h0, 4'h5};
   logic [7:0] tv [4] = '{8'h00, 8'h04, 8'h01, 8'h05};
   logic [4:0] ev [4] = '{5'h00, 5'h18, 5'h15, 5'h19};
   emp_pkg::emp_cfg_t cfg;
   int num_errors = 0;
   int cmp_count = 0;
   assign hready = hreadyout;
   emp_port_cfg uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .gigabit_speed_strap(1'b1),
      .port_role_strap(1'b1), .iface_type_strap(2'h3),
      .link_clk(link_clk), .link_rx_ctl(link_rx_ctl),
      .link_rxd(link_rxd), .cfg(cfg));
   emp_phy_model phy (.link_clk(link_clk), .status(st), .frame(frame),
      .link_rx_ctl(link_rx_ctl), .link_rxd(link_rxd));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      link_clk = 1'b0;
      #3;
      forever #16 link_clk = ~link_clk;
   end
   task automatic test_done;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One single transfer, waits on hready
   task automatic bus(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      q = hrdata;
      #1;
      if (n >= 50) begin
         num_errors++;
         test_done();
      end
   endtask
   task automatic rd(input logic [31:0] a, e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask
   task automatic wst(input logic [3:0] e);
      q = 32'hx;
      for (int i = 0; i < 40 && q[3:0] !== e; i++) bus(0, 32'hcc0c, 0);
      chk("stat", q, {28'h0, e});
   endtask
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, frame, htrans, haddr, hwdata, st} = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'hcc00, 32'h50, "ctrl0");
      rd(32'hcc04, 32'h4f, "ctrl1");
      chk("gig", {29'h0, cfg.speed_1000, cfg.speed_100,
         cfg.inband_enable}, 32'h5);
      foreach (sv[i]) begin
         st <= sv[i];
         wst(sv[i]);
      end
      frame <= 1'b1;
      repeat (30) @(posedge hclk);
      rd(32'hcc0c, 32'h05, "frame");
      frame <= 1'b0;
      bus(1, 32'hcc0c, 32'hff);
      rd(32'hcc0c, 32'hf5, "stat ro");
      bus(1, 32'hcc00, 32'hff);
      rd(32'hcc00, 32'h7f, "ctrl0 all");
      bus(1, 32'hcc04, 32'h0b);
      chk("s100", {30'h0, cfg.speed_100, cfg.inband_enable}, 2);
      st <= 4'h9;
      repeat (40) @(posedge hclk);
      rd(32'hcc0c, 32'hf5, "inband off");
      bus(1, 32'hcc04, 32'h0a);
      rd(32'hcc04, 32'h0b, "type rsv");
      foreach (tv[i]) begin
         bus(1, 32'hcc04, {24'h0, tv[i]});
         chk("role", {27'h0, cfg.txc_oe_n, cfg.rxc_oe_n,
            cfg.ref_clock_out_en, cfg.iface}, {27'h0, ev[i]});
      end
      bus(1, 32'hcc08, 32'hff);
      rd(32'hcc08, 32'h0, "unmapped");
      test_done();
   end
endmodule
`default_nettype wire
